// File: src/gsr_regs.svh
`ifndef GSR_REGS_SVH
`define GSR_REGS_SVH
// ****************************************
// Widths and array size
// ****************************************
`define GSR_PIX_W 10
`define GSR_DAC_W 7
`define GSR_ROWS 2048
`define GSR_COLS 2048
`define GSR_FIFO_DEPTH 32
// ****************************************
// Timing (clock 40 MHz)
// ****************************************
`define GSR_CLK_NS 25
`define GSR_FRAME_OVH_NS 5000
`define GSR_ROW_OVH_NS 200
`define GSR_FRAME_OVH_CYC 13'((`GSR_FRAME_OVH_NS + `GSR_CLK_NS - 1) / `GSR_CLK_NS)
`define GSR_ROW_OVH_CYC 13'((`GSR_ROW_OVH_NS + `GSR_CLK_NS - 1) / `GSR_CLK_NS)
// ****************************************
// Power-up flush counts
// ****************************************
`define GSR_FLUSH_COL 1024
`define GSR_FLUSH_ROW 2048
`define GSR_FLUSH_LAST 13'(2 * `GSR_FLUSH_ROW - 1)
`define GSR_FLUSH_COL_END 13'(2 * `GSR_FLUSH_COL)
// Converter pipeline depth in conversion clock falls
`define GSR_ADC_LAT 2
`endif

// File: src/gsr_pkg.sv
package gsr_pkg;
`include "gsr_regs.svh"
    // ****************************************
    // Controller states
    // ****************************************
    typedef enum logic [6:0] {
        C_FLUSH = 7'h01,
        C_IDLE = 7'h02,
        C_GRST = 7'h04,
        C_INTEG = 7'h08,
        C_FRAME_OVH = 7'h10,
        C_ROW_OVH = 7'h20,
        C_LINE = 7'h40
    } gsr_cst_t;
    // ****************************************
    // Controller state
    // ****************************************
    typedef struct packed {
        gsr_cst_t st;
        logic [12:0] cnt;
        logic [15:0] icnt;
        logic [11:0] row;
        logic [11:0] steps;
        logic ph;
        logic [1:0] v;
        logic [2:0] q;
        logic stp;
        logic row_sync;
        logic row_clk;
        logic col_sync;
        logic col_clk;
        logic adc_clk;
        logic rst_all;
        logic smp_all;
        logic cfg_load;
        logic supply_en;
        logic frame_done;
        logic [15:0] frame_idx;
    } gsr_ctrl_st_t;
    // ****************************************
    // Sensor state
    // ****************************************
    typedef struct packed {
        logic [11:0] row;
        logic [11:0] col;
        logic [`GSR_PIX_W-1:0] expo;
        logic [`GSR_PIX_W-1:0] stored;
        logic [`GSR_PIX_W-1:0] pa;
        logic [`GSR_PIX_W-1:0] pb;
        logic [`GSR_PIX_W-1:0] p0;
        logic [`GSR_PIX_W-1:0] p1;
        logic [`GSR_PIX_W-1:0] aout;
        logic row_clk_p;
        logic col_clk_p;
        logic adc_clk_p;
        logic load_p;
        logic [`GSR_DAC_W-1:0] dac;
        logic dual;
    } gsr_sens_st_t;
endpackage : gsr_pkg

// File: src/gsr_link_if.sv
`timescale 1ns/1ps
`include "gsr_regs.svh"
interface gsr_link_if;
    import gsr_pkg::*;
    // Controller to sensor
    logic row_sync;
    logic row_clk;
    logic col_sync;
    logic col_clk;
    logic adc_clk;
    logic rst_all;
    logic smp_all;
    logic cfg_load;
    logic [`GSR_DAC_W-1:0] dac_word;
    logic dual;
    // Sensor to controller
    logic [`GSR_PIX_W-1:0] pix_a;
    logic [`GSR_PIX_W-1:0] pix_b;
    logic [`GSR_PIX_W-1:0] adc_data;
    modport ctrl (
        output row_sync, row_clk, col_sync, col_clk, adc_clk,
        output rst_all, smp_all, cfg_load, dac_word, dual,
        input pix_a, pix_b, adc_data
    );
    modport sens (
        input row_sync, row_clk, col_sync, col_clk, adc_clk,
        input rst_all, smp_all, cfg_load, dac_word, dual,
        output pix_a, pix_b, adc_data
    );
endinterface : gsr_link_if

// File: src/gsr_fifo.sv
`timescale 1ns/1ps
module gsr_fifo #(
    parameter int W = 20,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] used
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_r, rp_r;
    logic wr, rd;
    // Handshakes and level
    assign used = wp_r - rp_r;
    assign in_ready = (used != (AW+1)'(DEPTH));
    assign out_valid = (used != '0);
    assign out_data = mem[rp_r[AW-1:0]];
    assign wr = in_valid & in_ready;
    assign rd = out_valid & out_ready;
    // Storage
    always_ff @(posedge clock) begin
        if (wr) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
    // Pointers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (wr) wp_r <= wp_r + 1'b1;
            if (rd) rp_r <= rp_r + 1'b1;
        end
    end
endmodule : gsr_fifo

// File: src/gsr_sensor.sv
`timescale 1ns/1ps
`include "gsr_regs.svh"
module gsr_sensor
    import gsr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Link
    gsr_link_if.sens lnk,
    // Scene and output stage
    input wire logic [3:0] light,
    output logic [`GSR_DAC_W-1:0] dc_ref,
    output logic stage_b_en
);
    gsr_sens_st_t s, n;
    logic upd;
    logic [`GSR_PIX_W:0] sum;

    // Pixel value at a row and column of the stored frame
    function automatic logic [`GSR_PIX_W-1:0] pv(input logic [`GSR_PIX_W-1:0] st,
                                                input logic [11:0] r, input logic [11:0] c);
        pv = st ^ {r[4:0], c[4:0]};
    endfunction : pv

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = s;
        upd = 1'b0;
        sum = {1'b0, s.expo} + {7'h0, light};
        // Whole array integrates and resets together
        if (lnk.rst_all) begin
            n.expo = '0;
        end else begin
            n.expo = sum[`GSR_PIX_W] ? '1 : sum[`GSR_PIX_W-1:0];
        end
        // Global transfer to in-pixel storage
        if (lnk.smp_all) begin
            n.stored = s.expo;
        end
        // Output stage settings on load rising edge
        n.load_p = lnk.cfg_load;
        if (lnk.cfg_load && !s.load_p) begin
            n.dac = lnk.dac_word;
            n.dual = lnk.dual;
        end
        // Row selection
        n.row_clk_p = lnk.row_clk;
        if (lnk.row_sync) begin
            n.row = '0;
        end else if (lnk.row_clk && !s.row_clk_p) begin
            n.row = s.row + 12'h1;
        end
        // Column scan, one pixel per edge or two in dual mode
        n.col_clk_p = lnk.col_clk;
        if (lnk.col_sync) begin
            n.col = '0;
            upd = 1'b1;
        end else if (lnk.col_clk != s.col_clk_p) begin
            n.col = s.col + (s.dual ? 12'h2 : 12'h1);
            upd = 1'b1;
        end
        if (upd) begin
            n.pa = pv(s.stored, s.row, n.col);
            n.pb = s.dual ? pv(s.stored, s.row, n.col + 12'h1) : '0;
        end
        // On-chip converter, sample on fall, output two falls later
        n.adc_clk_p = lnk.adc_clk;
        if (!lnk.adc_clk && s.adc_clk_p) begin
            n.p0 = s.pa;
            n.p1 = s.p0;
            n.aout = s.p1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Outputs
    assign lnk.pix_a = s.pa;
    assign lnk.pix_b = s.pb;
    assign lnk.adc_data = s.aout;
    assign dc_ref = s.dac;
    assign stage_b_en = s.dual;
endmodule : gsr_sensor

// File: src/gsr_ctrl.sv
`timescale 1ns/1ps
`include "gsr_regs.svh"
module gsr_ctrl
    import gsr_pkg::*;
#(
    parameter int ROWS = `GSR_ROWS,
    parameter int COLS = `GSR_COLS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Link
    gsr_link_if.ctrl lnk,
    // Frame control
    input wire logic start,
    input wire logic cont,
    input wire logic nondestructive_readout,
    input wire logic dual,
    input wire logic use_onchip,
    input wire logic [15:0] integ,
    input wire logic [`GSR_DAC_W-1:0] dac_word,
    // Status
    output logic supply_en,
    output logic busy,
    output logic frame_done,
    output logic [15:0] frame_idx,
    // Pixel stream
    output logic out_valid,
    input wire logic out_ready,
    output logic [2*`GSR_PIX_W-1:0] out_data
);
    localparam int FW = 2 * `GSR_PIX_W;
    localparam int AW = $clog2(`GSR_FIFO_DEPTH);

    gsr_ctrl_st_t s, n;
    logic dmode, slot, room, step, push, done;
    logic [11:0] nsteps;
    logic [FW-1:0] push_data;
    logic [AW:0] used;

    // Dual stage only with the external converter path
    assign dmode = dual & ~use_onchip;
    assign nsteps = dmode ? 12'(COLS / 2) : 12'(COLS);
    // Keep room for the captures still in flight
    assign room = used < (AW+1)'(`GSR_FIFO_DEPTH - 3);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = s;
        step = 1'b0;
        push = 1'b0;
        push_data = '0;
        slot = 1'b0;
        done = 1'b0;
        n.frame_done = 1'b0;
        n.cfg_load = 1'b0;
        n.row_sync = 1'b0;
        n.col_sync = 1'b0;
        n.rst_all = 1'b0;
        // Integration timer runs beside readout
        if (s.icnt != '0) begin
            n.icnt = s.icnt - 16'h1;
        end
        case (s.st)
            C_FLUSH: begin
                // Clocking begins straight out of reset
                n.cnt = s.cnt + 13'h1;
                n.row_clk = ~s.cnt[0];
                n.col_clk = ~s.cnt[0] & (s.cnt < `GSR_FLUSH_COL_END);
                if (s.cnt == `GSR_FLUSH_LAST) begin
                    n.row_clk = 1'b0;
                    n.col_clk = 1'b0;
                    n.supply_en = 1'b1;
                    n.st = C_IDLE;
                end
            end
            C_IDLE: begin
                if (start) begin
                    n.cfg_load = 1'b1;
                    n.rst_all = 1'b1;
                    n.st = C_GRST;
                end
            end
            C_GRST: begin
                n.icnt = integ;
                n.st = C_INTEG;
            end
            C_INTEG: begin
                if (s.icnt == '0) begin
                    n.smp_all = 1'b1;
                    n.row_sync = 1'b1;
                    n.cnt = `GSR_FRAME_OVH_CYC - 13'h1;
                    n.st = C_FRAME_OVH;
                end
            end
            C_FRAME_OVH: begin
                if (s.cnt == '0) begin
                    n.smp_all = 1'b0;
                    // Overlapped mode starts the next exposure now
                    if (cont && !nondestructive_readout) begin
                        n.rst_all = 1'b1;
                        n.icnt = integ;
                    end
                    n.row = '0;
                    n.cnt = `GSR_ROW_OVH_CYC - 13'h1;
                    n.st = C_ROW_OVH;
                end else begin
                    n.cnt = s.cnt - 13'h1;
                end
            end
            C_ROW_OVH: begin
                n.row_clk = 1'b0;
                if (s.cnt == '0) begin
                    n.steps = '0;
                    n.ph = 1'b0;
                    n.st = C_LINE;
                end else begin
                    n.cnt = s.cnt - 13'h1;
                end
            end
            C_LINE: begin
                n.ph = ~s.ph;
                // Half rate when both stages or the converter are used
                slot = ~(dmode | use_onchip) | ~s.ph;
                if (s.steps != nsteps && slot && room) begin
                    step = 1'b1;
                    n.steps = s.steps + 12'h1;
                    if (s.steps == '0) begin
                        n.col_sync = 1'b1;
                    end else begin
                        n.col_clk = ~s.col_clk;
                    end
                end
                if (use_onchip) begin
                    if (!s.ph) begin
                        n.adc_clk = 1'b1;
                        n.stp = step;
                    end else begin
                        n.adc_clk = 1'b0;
                        n.q = {s.q[1:0], s.stp};
                        // Word seen now was sampled two falls earlier
                        if (s.q[`GSR_ADC_LAT]) begin
                            push = 1'b1;
                            push_data = {{`GSR_PIX_W{1'b0}}, lnk.adc_data};
                        end
                    end
                end else begin
                    n.v = {s.v[0], step};
                    if (s.v[1]) begin
                        push = 1'b1;
                        push_data = {lnk.pix_b, lnk.pix_a};
                    end
                end
                done = (s.steps == nsteps) && (s.v == '0) && (s.q == '0) &&
                       !s.stp && (!use_onchip || s.ph);
                if (done) begin
                    n.row = s.row + 12'h1;
                    n.adc_clk = 1'b0;
                    n.v = '0;
                    if (s.row + 12'h1 == 12'(ROWS)) begin
                        n.frame_done = 1'b1;
                        n.frame_idx = s.frame_idx + 16'h1;
                        if (cont) begin
                            // Nondestructive frames skip the reset
                            if (nondestructive_readout) begin
                                n.icnt = integ;
                            end
                            n.st = C_INTEG;
                        end else begin
                            n.st = C_IDLE;
                        end
                    end else begin
                        n.row_clk = 1'b1;
                        n.cnt = `GSR_ROW_OVH_CYC - 13'h1;
                        n.st = C_ROW_OVH;
                    end
                end
            end
            default: begin
                n.st = C_IDLE;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.st <= C_FLUSH;
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // Pixel buffer
    // ****************************************
    gsr_fifo #(
        .W(FW),
        .DEPTH(`GSR_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(),
        .in_data(push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data),
        .used(used)
    );

    // Link and status outputs
    assign lnk.row_sync = s.row_sync;
    assign lnk.row_clk = s.row_clk;
    assign lnk.col_sync = s.col_sync;
    assign lnk.col_clk = s.col_clk;
    assign lnk.adc_clk = s.adc_clk;
    assign lnk.rst_all = s.rst_all;
    assign lnk.smp_all = s.smp_all;
    assign lnk.cfg_load = s.cfg_load;
    assign lnk.dac_word = dac_word;
    // Sensor steps one pixel per edge whenever the converter path is used
    assign lnk.dual = dmode;
    assign supply_en = s.supply_en;
    assign busy = ~(s.st == C_IDLE);
    assign frame_done = s.frame_done;
    assign frame_idx = s.frame_idx;
endmodule : gsr_ctrl

// File: verif/gsr_link_props.sv
`timescale 1ns/1ps
`include "gsr_regs.svh"
module gsr_link_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Link signals
    input wire logic row_clk,
    input wire logic col_sync,
    input wire logic col_clk,
    input wire logic adc_clk,
    input wire logic rst_all,
    input wire logic smp_all,
    input wire logic cfg_load,
    input wire logic [`GSR_PIX_W-1:0] pix_a,
    input wire logic [`GSR_PIX_W-1:0] adc_data
);
    // ********
    // Helper state
    // ********
    logic [12:0] cyc_r;
    logic [12:0] rows_r;
    logic [12:0] cols_r;
    logic [8:0] frame_ovh_r;
    logic row_p_r;
    logic col_p_r;
    logic adc_p_r;
    logic [9:0] s0_r;
    logic [9:0] s1_r;
    logic [9:0] s2_r;
    // Cycle count, flush pulses, overhead length, converter samples
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {cyc_r, rows_r, cols_r, frame_ovh_r, row_p_r, col_p_r, adc_p_r, s0_r, s1_r, s2_r} <= '0;
        end else begin
            cyc_r <= (cyc_r == 13'h1fff) ? cyc_r : cyc_r + 13'h1;
            row_p_r <= row_clk;
            col_p_r <= col_clk;
            adc_p_r <= adc_clk;
            frame_ovh_r <= smp_all ? frame_ovh_r + 9'h1 : 9'h0;
            if (cyc_r < 13'h1004 && row_clk && !row_p_r) begin
                rows_r <= rows_r + 13'h1;
            end
            if (cyc_r < 13'h1004 && col_clk && !col_p_r) begin
                cols_r <= cols_r + 13'h1;
            end
            if (adc_p_r && !adc_clk) begin
                s0_r <= pix_a;
                s1_r <= s0_r;
                s2_r <= s1_r;
            end
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    flush_pulses_a: assert property (cyc_r == 13'h1004 |->
        rows_r == 13'h0800 && cols_r == 13'h0400) else $error("flush pulse count wrong");
    flush_quiet_a: assert property (cyc_r < 13'h1000 |-> !smp_all && !rst_all)
        else $error("frame activity during flush");
    frame_ovh_len_a: assert property ($fell(smp_all) |-> frame_ovh_r == 9'h0c8)
        else $error("frame overhead length wrong");
    first_line_a: assert property ($fell(smp_all) |-> !col_sync [*7] ##[1:3] col_sync)
        else $error("row overhead after frame overhead wrong");
    row_to_line_a: assert property (cyc_r > 13'h1004 && $rose(row_clk) |->
        !col_sync [*7] ##[1:3] col_sync) else $error("line start after row step wrong");
    cfg_reset_a: assert property (cfg_load |-> rst_all)
        else $error("config load without global reset");
    cfg_pulse_a: assert property (cfg_load |=> !cfg_load && !smp_all)
        else $error("config load pulse too long");
    adc_delay_a: assert property ($fell(adc_clk) |=> adc_data == s2_r)
        else $error("converter latency wrong");
endmodule : gsr_link_props

// File: verif/global_shutter_readout_sequencing_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module global_shutter_readout_sequencing_bench;
    import gsr_pkg::*;
    // ********
    // Signals
    // ********
    localparam int ROWS = 4;
    localparam int COLS = 16;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic cont = 1'b0;
    logic nondestructive_readout = 1'b0;
    logic dual = 1'b0;
    logic use_onchip = 1'b0;
    logic out_ready = 1'b1;
    logic [3:0] light = 4'h0;
    logic [15:0] integ = 16'h0064;
    logic [6:0] dac_word = 7'h00;
    logic supply_en, busy, frame_done, out_valid, stage_b_en;
    logic [15:0] frame_idx;
    logic [19:0] out_data;
    logic [6:0] dc_ref;
    int fails = 0;
    int n_tests = 0;
    int n_rst = 0;
    int n;
    int k;
    logic [19:0] q[$];
    // ********
    // Design and checker
    // ********
    gsr_link_if lnk ();
    gsr_ctrl #(.ROWS(ROWS), .COLS(COLS)) gsr_ctrl_inst (.clock(clock), .rstn(rstn), .lnk(lnk),
        .start(start), .cont(cont), .nondestructive_readout(nondestructive_readout),
        .dual(dual), .use_onchip(use_onchip),
        .integ(integ), .dac_word(dac_word), .supply_en(supply_en), .busy(busy),
        .frame_done(frame_done), .frame_idx(frame_idx), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data));
    gsr_sensor gsr_sensor_inst (.clock(clock), .rstn(rstn), .lnk(lnk), .light(light),
        .dc_ref(dc_ref), .stage_b_en(stage_b_en));
    gsr_link_props gsr_link_props_inst (.clock(clock), .rstn(rstn), .row_clk(lnk.row_clk),
        .col_sync(lnk.col_sync), .col_clk(lnk.col_clk), .adc_clk(lnk.adc_clk),
        .rst_all(lnk.rst_all), .smp_all(lnk.smp_all), .cfg_load(lnk.cfg_load),
        .pix_a(lnk.pix_a), .adc_data(lnk.adc_data));
    // Clock
    always #12.5 clock = ~clock;
    // Capture words that the coming edge accepts
    always @(negedge clock) if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back(out_data);
    // Count global resets
    always @(posedge lnk.rst_all) n_rst++;
    // ********
    // Tasks
    // ********
    function automatic logic [9:0] pix(int r, int c, logic [9:0] x);
        return x ^ {r[4:0], c[4:0]};
    endfunction : pix
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic go(logic [3:0] l, logic d, logic oc, logic [6:0] dw, logic ct, logic nd);
        @(posedge clock);
        light <= l;
        dual <= d;
        use_onchip <= oc;
        dac_word <= dw;
        cont <= ct;
        nondestructive_readout <= nd;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
    endtask : go
    task automatic wait_done();
        int i;
        i = 0;
        while (frame_done !== 1'b1 && i < 20000) begin @(negedge clock); i++; end
        `CHK(i < 20000, 1'b1)
        @(negedge clock);
    endtask : wait_done
    task automatic wait_smp_fall();
        int i;
        i = 0;
        while (lnk.smp_all !== 1'b1 && i < 20000) begin @(negedge clock); i++; end
        while (lnk.smp_all !== 1'b0 && i < 20000) begin @(negedge clock); i++; end
        `CHK(i < 20000, 1'b1)
    endtask : wait_smp_fall
    task automatic check_frame(logic [9:0] x);
        logic [19:0] e;
        logic [19:0] g;
        int st;
        st = (dual && !use_onchip) ? 2 : 1;
        repeat (40) @(negedge clock);
        for (int r = 0; r < ROWS; r++) begin
            for (int c = 0; c < COLS; c += st) begin
                e = (st == 2) ? {pix(r, c + 1, x), pix(r, c, x)} : {10'h000, pix(r, c, x)};
                g = (q.size() > 0) ? q.pop_front() : 20'hxxxxx;
                `CHK(g, e)
            end
        end
    endtask : check_frame
    // ********
    // Sequence
    // ********
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        #1 `CHK(busy, 1'b1)
        n = 0;
        while (supply_en !== 1'b1 && n < 5000) begin @(negedge clock); n++; end
        `CHK(n > 4095 && n < 4099, 1'b1)
        // Saturated exposure, drain stalled until stepping holds back
        @(posedge clock) out_ready <= 1'b0;
        go(4'hf, 1'b0, 1'b0, 7'h5a, 1'b0, 1'b0);
        repeat (400) @(posedge clock);
        out_ready <= 1'b1;
        wait_done();
        `CHK(dc_ref, 7'h5a)
        `CHK(stage_b_en, 1'b0)
        check_frame(10'h3ff);
        // Old exposure cleared, storage frozen after transfer, two stages
        go(4'h0, 1'b1, 1'b0, 7'h7f, 1'b0, 1'b0);
        wait_smp_fall();
        @(posedge clock) light <= 4'hf;
        wait_done();
        `CHK(dc_ref, 7'h7f)
        `CHK(stage_b_en, 1'b1)
        check_frame(10'h000);
        // On-chip converter path
        go(4'h0, 1'b0, 1'b1, 7'h00, 1'b0, 1'b0);
        wait_done();
        check_frame(10'h000);
        // Pipelined: next frame integrates during readout
        go(4'h0, 1'b0, 1'b0, 7'h11, 1'b1, 1'b0);
        wait_smp_fall();
        @(posedge clock) light <= 4'hf;
        wait_done();
        @(posedge clock) light <= 4'h0;
        cont <= 1'b0;
        wait_done();
        check_frame(10'h000);
        check_frame(10'h3ff);
        // Nondestructive: one reset, repeated reads
        k = n_rst;
        go(4'hf, 1'b0, 1'b0, 7'h22, 1'b1, 1'b1);
        wait_done();
        @(posedge clock) light <= 4'h0;
        cont <= 1'b0;
        wait_done();
        `CHK(n_rst - k, 1)
        check_frame(10'h3ff);
        check_frame(10'h3ff);
        `CHK(q.size(), 0)
        // Seven frames in all, controller back at rest
        `CHK(frame_idx, 16'h0007)
        `CHK(busy, 1'b0)
        stop_test();
    end
    // Watchdog
    initial begin
        #1000000;
        fails++;
        stop_test();
    end
endmodule : global_shutter_readout_sequencing_bench
